// ---- common/spg_pkg.sv ----
// Purpose: shared constants and types for the sector protection block
// Assumes: sixteen sectors of 64KB, 24-bit addresses sent MSB first
// Notes: the summary encoding is local to this block
package spg_pkg;
    localparam int NUM_SECT = 16;
    localparam logic [7:0] OP_RD_PROT = 8'h3C;
    // status byte 1 field positions
    localparam int LOCK_POS = 7;
    localparam int GLOB_HI = 5;
    localparam int GLOB_LO = 2;
    localparam logic [3:0] GLOB_ALL_ZERO = 4'h0;
    localparam logic [3:0] GLOB_ALL_ONE = 4'hF;
    // sector index is A19..A16, the low nibble of the first address byte
    localparam int SECT_HI = 3;
    localparam int SECT_LO = 0;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    // reset values: every sector protected, lock released
    localparam logic [15:0] PROT_RESET = 16'hFFFF;
    localparam logic LOCK_RESET = 1'b0;
    // protection summary codes
    localparam logic [1:0] SUM_NONE = 2'h0;
    localparam logic [1:0] SUM_SOME = 2'h1;
    localparam logic [1:0] SUM_ALL = 2'h3;
    typedef enum logic [3:0] {
        ST_OP = 4'h1,
        ST_ADDR = 4'h2,
        ST_OUT = 4'h4,
        ST_SKIP = 4'h8
    } spg_state_type;
endpackage

// ---- logic/spg_spi_rx.sv ----
// Purpose: oversampled serial receiver for chip select, clock and data in
// Assumes: SPI mode 0 or 3; serial clock well below a quarter of CLK_SYS
// Notes: all pins pass two flip-flops before any logic looks at them
module spg_spi_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic cs_act,
    output logic sck_fall,
    output logic byte_stb,
    output logic [7:0] byte_data
);
    logic cs_m_reg, cs_s_reg;
    logic sck_m_reg, sck_s_reg, sck_d_reg;
    logic si_m_reg, si_s_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic sck_rise;

    // two-stage synchronisers, idle values while in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            sck_m_reg <= 1'b0;
            sck_s_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            si_m_reg <= 1'b0;
            si_s_reg <= 1'b0;
        end else begin
            cs_m_reg <= cs_n;
            cs_s_reg <= cs_m_reg;
            sck_m_reg <= sck;
            sck_s_reg <= sck_m_reg;
            sck_d_reg <= sck_s_reg;
            si_m_reg <= si;
            si_s_reg <= si_m_reg;
        end
    end

    // edges only count inside a frame, so mode 3 idle-high is harmless
    assign cs_act = ~cs_s_reg;
    assign sck_rise = cs_act & sck_s_reg & ~sck_d_reg;
    assign sck_fall = cs_act & ~sck_s_reg & sck_d_reg;

    // shift in on rising edges, flag each complete byte for one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            byte_stb <= 1'b0;
            byte_data <= 8'h00;
        end else if (!cs_act) begin
            bit_cnt_reg <= 3'h0; // partial bytes are dropped at frame end
            byte_stb <= 1'b0;
        end else begin
            byte_stb <= sck_rise && (bit_cnt_reg == 3'h7);
            if (sck_rise) begin
                shift_reg <= {shift_reg[5:0], si_s_reg};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_data <= {shift_reg, si_s_reg};
                end
            end
        end
    end
endmodule

// ---- logic/spg_sector_protect.sv ----
// Purpose: global protect/unprotect decode, lock handling and readback
// Assumes: status byte 1 writes arrive as a one-cycle strobe from the
//          command decoder, already qualified by the write enable latch
// Notes: WP_N is asserted low; serial pins are oversampled by CLK_SYS
// Function
// - unlocked write with bits 5..2 all zero clears every sector bit
// - unlocked write with bits 5..2 all one sets every sector bit
// - any other bits 5..2 pattern leaves sector bits unchanged
// - pin low and lock set: global patterns ignored, sector bits kept
// - hard-locked: lock bit cannot change until the pin goes high
// - pin high and lock set: no global change on a status write
// - soft-locked write with bit 7 clear releases lock, no global change
// - after last address byte, a data bit is driven every clock
// - repeating byte is 00h when sector unprotected, FFh when protected
// - readback reflects only the sector bit, never the pin level
// - chip select high ends readback and floats data out at any bit
// - summary bits tell all, some or no sectors protected
// - only bit 7 of status byte 1 is stored, as the lock
// - global protect during suspend aborts and clears write enable latch
module spg_sector_protect (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic SPI_SI,
    output logic SPI_SO,
    output logic SPI_SO_OE,
    input wire logic WP_N,
    input wire logic SR1_WR_STB,
    input wire logic [7:0] SR1_WR_DATA,
    input wire logic SUSPEND_ACTIVE,
    output logic [15:0] SECTOR_PROT,
    output logic PROT_LOCK,
    output logic [1:0] PROT_SUMMARY,
    output logic WEL_CLR
);
    logic cs_act, sck_fall, byte_stb;
    logic [7:0] byte_data;
    logic wp_m_reg, wp_s_reg;
    logic [15:0] prot_reg;
    logic lock_reg;
    logic [1:0] summary_reg;
    logic wel_clr_reg;
    logic so_reg, so_oe_reg;
    logic [3:0] sel_reg;
    logic [1:0] addr_cnt_reg;
    spg_pkg::spg_state_type state_reg;
    logic [3:0] glob;
    logic hard_lock, soft_lock;

    // summary of a protection vector
    function automatic logic [1:0] summarize(input logic [15:0] v);
        if (v == spg_pkg::PROT_RESET) begin
            return spg_pkg::SUM_ALL;
        end else if (v == 16'h0000) begin
            return spg_pkg::SUM_NONE;
        end
        return spg_pkg::SUM_SOME;
    endfunction

    spg_spi_rx u_rx (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .cs_n(SPI_CS_N),
        .sck(SPI_SCK),
        .si(SPI_SI),
        .cs_act(cs_act),
        .sck_fall(sck_fall),
        .byte_stb(byte_stb),
        .byte_data(byte_data)
    );

    // write-protect pin is asynchronous, synchronise before use
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            wp_m_reg <= 1'b1;
            wp_s_reg <= 1'b1;
        end else begin
            wp_m_reg <= WP_N;
            wp_s_reg <= wp_m_reg;
        end
    end

    assign glob = SR1_WR_DATA[spg_pkg::GLOB_HI:spg_pkg::GLOB_LO];
    assign hard_lock = lock_reg & ~wp_s_reg;
    assign soft_lock = lock_reg & wp_s_reg;

    // lock bit: only bit 7 of the written byte is ever stored
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            lock_reg <= spg_pkg::LOCK_RESET;
        end else if (SR1_WR_STB && !hard_lock) begin
            if (soft_lock) begin
                if (!SR1_WR_DATA[spg_pkg::LOCK_POS]) begin
                    lock_reg <= 1'b0;
                end
            end else begin
                lock_reg <= SR1_WR_DATA[spg_pkg::LOCK_POS];
            end
        end
    end

    // global protect/unprotect, only when the lock is clear at write time;
    // a soft unlock therefore never acts on the same write
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            prot_reg <= spg_pkg::PROT_RESET;
            wel_clr_reg <= 1'b0;
        end else begin
            wel_clr_reg <= 1'b0;
            if (SR1_WR_STB && !lock_reg) begin
                if (glob == spg_pkg::GLOB_ALL_ZERO) begin
                    prot_reg <= 16'h0000;
                end else if (glob == spg_pkg::GLOB_ALL_ONE) begin
                    if (SUSPEND_ACTIVE) begin
                        wel_clr_reg <= 1'b1;
                    end else begin
                        prot_reg <= spg_pkg::PROT_RESET;
                    end
                end // other patterns fall through unchanged
            end
        end
    end

    // summary lags the sector bits by one cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            summary_reg <= spg_pkg::SUM_ALL;
        end else begin
            summary_reg <= summarize(prot_reg);
        end
    end

    // read-protection command sequencer
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            state_reg <= spg_pkg::ST_OP;
            addr_cnt_reg <= 2'h0;
            sel_reg <= 4'h0;
        end else if (!cs_act) begin
            state_reg <= spg_pkg::ST_OP;
            addr_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                spg_pkg::ST_OP: begin
                    if (byte_stb) begin
                        if (byte_data == spg_pkg::OP_RD_PROT) begin
                            state_reg <= spg_pkg::ST_ADDR;
                        end else begin
                            state_reg <= spg_pkg::ST_SKIP;
                        end
                    end
                end
                spg_pkg::ST_ADDR: begin
                    if (byte_stb) begin
                        addr_cnt_reg <= addr_cnt_reg + 2'h1;
                        if (addr_cnt_reg == 2'h0) begin
                            sel_reg <= byte_data[spg_pkg::SECT_HI:
                                                 spg_pkg::SECT_LO];
                        end
                        if (addr_cnt_reg == spg_pkg::LAST_ADDR_BYTE) begin
                            state_reg <= spg_pkg::ST_OUT;
                        end
                    end
                end
                spg_pkg::ST_OUT: state_reg <= spg_pkg::ST_OUT;
                spg_pkg::ST_SKIP: state_reg <= spg_pkg::ST_SKIP;
                default: state_reg <= spg_pkg::ST_OP;
            endcase
        end
    end

    // data out: each falling edge presents the sector bit, so every bit of
    // the byte is equal and the byte repeats with no counter needed
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (!cs_act) begin
            so_oe_reg <= 1'b0;
        end else if (state_reg == spg_pkg::ST_OUT && sck_fall) begin
            so_reg <= prot_reg[sel_reg];
            so_oe_reg <= 1'b1;
        end
    end

    assign SPI_SO = so_reg;
    assign SPI_SO_OE = so_oe_reg;
    assign SECTOR_PROT = prot_reg;
    assign PROT_LOCK = lock_reg;
    assign PROT_SUMMARY = summary_reg;
    assign WEL_CLR = wel_clr_reg;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    a_glob_unprot: assert property (
        SR1_WR_STB && !lock_reg && glob == 4'h0 |=> prot_reg == 16'h0000)
        else $error("global unprotect did not clear sectors");
    a_glob_prot: assert property (
        SR1_WR_STB && !lock_reg && glob == 4'hF && !SUSPEND_ACTIVE
        |=> prot_reg == 16'hFFFF)
        else $error("global protect did not set sectors");
    a_mixed_keep: assert property (
        SR1_WR_STB && glob != 4'h0 && glob != 4'hF |=> $stable(prot_reg))
        else $error("mixed pattern changed sectors");
    a_hard_keep: assert property (
        SR1_WR_STB && lock_reg && !wp_s_reg |=> $stable(prot_reg))
        else $error("hard lock let sectors change");
    a_hard_lock_bit: assert property (
        SR1_WR_STB && lock_reg && !wp_s_reg |=> lock_reg)
        else $error("hard lock let lock bit change");
    a_soft_keep: assert property (
        SR1_WR_STB && lock_reg && wp_s_reg |=> $stable(prot_reg))
        else $error("soft lock let sectors change");
    a_soft_release: assert property (
        SR1_WR_STB && soft_lock && !SR1_WR_DATA[7] |=> !lock_reg)
        else $error("soft lock not released");
    a_lock_store: assert property (
        SR1_WR_STB && !lock_reg |=> lock_reg == $past(SR1_WR_DATA[7]))
        else $error("lock bit not taken from bit 7");
    a_suspend_abort: assert property (
        SR1_WR_STB && !lock_reg && glob == 4'hF && SUSPEND_ACTIVE
        |=> wel_clr_reg && $stable(prot_reg))
        else $error("suspended global protect not aborted");
    a_out_drive: assert property (
        state_reg == spg_pkg::ST_OUT && sck_fall && cs_act
        |=> so_oe_reg && so_reg == $past(prot_reg[sel_reg]))
        else $error("readback bit wrong or not driven");
    a_cs_float: assert property (
        !cs_act |=> !so_oe_reg)
        else $error("data out driven outside frame");
    a_summary_none: assert property (
        prot_reg == 16'h0000 ##1 prot_reg == 16'h0000
        |-> summary_reg == 2'h0)
        else $error("summary not none");

    c_glob_prot: cover property (SR1_WR_STB && !lock_reg && glob == 4'hF);
    c_glob_unprot: cover property (SR1_WR_STB && !lock_reg && glob == 4'h0);
    c_soft_unlock: cover property (SR1_WR_STB && soft_lock);
    c_readback: cover property (state_reg == spg_pkg::ST_OUT && so_oe_reg);
endmodule

// ---- test/spg_host_model.sv ----
// Purpose: host side serial model that issues sector protection reads
// Assumes: mode 0, each serial clock phase lasts 8 system clocks, 9 for the low phase that ends a readback byte
// Notes: each whole byte read back is reported on rd_stb with its enable
module spg_host_model (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic rd_stb,
    output logic [8:0] rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: select high, clock parked low
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        si = 1'h0;
        rd_stb = 1'h0;
        rd_byte = 9'h000;
    end

    // one frame: opcode, three address bytes, then nbits of readback
    task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                         input int nbits);
        logic [31:0] cmd;
        logic oe_all;
        logic [7:0] acc;
        cmd = {op, addr};
        oe_all = 1'h1;
        acc = 8'h00;
        @(negedge clk) cs_n = 1'h0;
        for (int i = 0; i < 32 + nbits; i++) begin
            repeat (8) @(negedge clk);
            sck = 1'h0;
            // past the address the line is unused, so it toggles
            si = (i < 32) ? cmd[31 - i] : ~si;
            repeat (8) @(negedge clk);
            if (i >= 32) begin
                // a bit is taken only while the pin is really driven
                oe_all = oe_all & so_oe;
                acc = {acc[6:0], so & so_oe};
                if ((i - 32) % 8 == 7) begin
                    rd_byte = {oe_all, acc};
                    oe_all = 1'h1;
                    rd_stb = 1'h1;
                    @(negedge clk) rd_stb = 1'h0;
                end
            end
            sck = 1'h1;
        end
        repeat (8) @(negedge clk);
        sck = 1'h0;
        repeat (4) @(negedge clk);
        cs_n = 1'h1;
        si = ~si;
    endtask
endmodule

// ---- test/tb_spg_sector_protect.sv ----
// Purpose: self-checking bench for the sector protection block
// Assumes: status writes and pins from the bench, reads from the host model
// Notes: expected results queue up; a watcher compares them in order
module tb_spg_sector_protect;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic wp_n = 1'h1;
    logic stb = 1'h0;
    logic [7:0] data = 8'h00;
    logic susp = 1'h0;
    // suspend level for the next write, applied together with its strobe
    logic susp_n = 1'h0;
    logic cs_n, sck, si, so, so_oe, wel_clr, lock, host_stb;
    logic [15:0] prot;
    logic [1:0] summary;
    logic [8:0] host_byte;
    logic [19:0] wq[$];
    logic [8:0] rq[$];
    logic [17:0] obs;
    logic d1 = 1'h0;
    logic d2 = 1'h0;
    logic [15:0] m_prot = spg_pkg::PROT_RESET;
    logic m_lock = spg_pkg::LOCK_RESET;
    logic [7:0] d;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    spg_sector_protect i_spg_sector_protect (.CLK_SYS(clk_sys),
        .RESET_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SI(si),
        .SPI_SO(so), .SPI_SO_OE(so_oe), .WP_N(wp_n), .SR1_WR_STB(stb),
        .SR1_WR_DATA(data), .SUSPEND_ACTIVE(susp), .SECTOR_PROT(prot),
        .PROT_LOCK(lock), .PROT_SUMMARY(summary), .WEL_CLR(wel_clr));
    spg_host_model i_spg_host_model (.clk(clk_sys), .so(so), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si), .rd_stb(host_stb),
        .rd_byte(host_byte));

    task automatic check(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watcher: status results settle over two cycles, bytes come from host
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        d1 <= stb;
        d2 <= d1;
        if (d1)
            obs <= {lock, wel_clr, prot};
        if (d2)
            check("status", wq.pop_front(), {obs, summary});
        if (host_stb)
            check("readback", 20'(rq.pop_front()), 20'(host_byte));
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // reference decision is made on the lock value before the write
    task automatic wr(input logic [7:0] v);
        logic w;
        logic [1:0] s;
        w = 1'h0;
        if (!m_lock) begin
            if (v[5:2] == spg_pkg::GLOB_ALL_ONE && susp_n)
                w = 1'h1;
            else if (v[5:2] == spg_pkg::GLOB_ALL_ONE)
                m_prot = 16'hFFFF;
            else if (v[5:2] == spg_pkg::GLOB_ALL_ZERO)
                m_prot = 16'h0000;
            m_lock = v[7];
        end else if (wp_n)
            m_lock = v[7];
        s = (m_prot == 16'h0000) ? spg_pkg::SUM_NONE :
            (m_prot == 16'hFFFF) ? spg_pkg::SUM_ALL : spg_pkg::SUM_SOME;
        wq.push_back({m_lock, w, m_prot, s});
        @(negedge clk_sys);
        stb = 1'h1;
        data = v;
        susp = susp_n;
    endtask

    task automatic idle;
        @(negedge clk_sys) stb = 1'h0;
    endtask

    // pin goes through synchronisers, so let it settle before writes
    task automatic set_wp(input logic v);
        idle();
        wp_n = v;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] op, input logic [3:0] s, input int nb);
        for (int k = 0; k < nb / 8; k++)
            rq.push_back(op == spg_pkg::OP_RD_PROT ? {1'h1, {8{m_prot[s]}}}
                                                   : 9'h000);
        i_spg_host_model.frame(op, {4'h0, s, 16'($urandom)}, nb);
        repeat (8) @(negedge clk_sys);
        check("data out enable", 20'h00000, {19'h00000, so_oe});
    endtask

    initial begin
        void'($urandom(38821));
        repeat (8) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (4) @(negedge clk_sys);
        rd(spg_pkg::OP_RD_PROT, 4'h5, 16);
        wr(8'h04);
        wr(8'h38);
        wr(8'h00);
        idle();
        rd(spg_pkg::OP_RD_PROT, 4'h3, 16);
        wr(8'h7F);
        wr(8'h80);
        wr(8'h7F);
        wr(8'h7F);
        wr(8'hF0);
        set_wp(1'h0);
        wr(8'h00);
        wr(8'h0F);
        idle();
        rd(spg_pkg::OP_RD_PROT, 4'h9, 16);
        rd(8'h9F, 4'h9, 16);
        rd(spg_pkg::OP_RD_PROT, 4'hF, 21);
        set_wp(1'h1);
        wr(8'h0F);
        wr(8'h00);
        susp_n = 1'h1;
        wr(8'h3C);
        wr(8'h80);
        for (int k = 0; k < 48; k++) begin
            if (k % 12 == 11)
                set_wp(1'($urandom));
            susp_n = 1'($urandom);
            d = 8'($urandom);
            if (d[0])
                d[5:2] = {4{d[1]}};
            wr(d);
            if (k % 8 == 7) begin
                idle();
                rd(spg_pkg::OP_RD_PROT, 4'($urandom), 16);
            end
        end
        idle();
        repeat (8) @(negedge clk_sys);
        if (wq.size() + rq.size() != 0)
            bad_count++;
        give_verdict();
    end
endmodule
